// ==== icis_pkg.sv ====
// package: register map, field positions and reset values of the
// input change and interrupt status block.
// assumes a 32-bit ahb-lite register bus, one word per register.
package icis_pkg;
    // ========================================================
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_INPUT_CHANGE = 6'h04; // read
    localparam logic [5:0] IDX_AUX_CONTROL = 6'h04; // write
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h05; // read
    localparam logic [5:0] IDX_IRQ_MASK = 6'h05; // write
    localparam logic [5:0] IDX_COMMAND = 6'h06; // write
    localparam logic [5:0] IDX_AUX_READBACK = 6'h07; // read
    localparam logic [5:0] IDX_MASK_READBACK = 6'h08; // read
    // ========================================================
    // status bit positions
    localparam int ST_INPUT_CHG = 7;
    localparam int ST_BREAK_B = 6;
    localparam int ST_RX_B = 5;
    localparam int ST_TX_B = 4;
    localparam int ST_COUNTER = 3;
    localparam int ST_BREAK_A = 2;
    localparam int ST_RX_A = 1;
    localparam int ST_TX_A = 0;
    // command bits, write one to act
    localparam int CMD_CLR_BREAK_A = 0;
    localparam int CMD_CLR_BREAK_B = 1;
    localparam int CMD_STOP_COUNTER = 2;
    // ========================================================
    // reset values and sizes
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam int NUM_PINS = 4;
    localparam logic [1:0] PRIME_DONE = 2'h3;
endpackage

// ==== icis_chg_if.sv ====
// interface: pin change detector to register logic.
// assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface icis_chg_if;
    logic [3:0] level;  // synchronised live pin levels
    logic [3:0] change; // one-cycle pulse per pin edge
    logic [3:0] delta;  // latched change flags
    logic clear;        // clear latched flags this cycle
    modport det (output level, output change, output delta,
        input clear);
    modport ctl (input level, input change, input delta,
        output clear);
endinterface
`default_nettype wire

// ==== icis_chg_det.sv ====
// module: synchroniser and change detector for the input pins.
// assumes asynchronous pins and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module icis_chg_det (
    input wire logic clock,           // system clock
    input wire logic reset,           // sync reset, high
    input wire logic [3:0] pins,      // raw asynchronous pins
    icis_chg_if.det chg               // detector side
);
    import icis_pkg::*;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [3:0] change;
        logic [3:0] delta;
        logic [1:0] prime;
    } icis_det_st_t;

    icis_det_st_t st_reg;
    icis_det_st_t st_next;

    // ========================================================
    // detection
    always_comb begin
        logic [3:0] edges;
        edges = 4'h0;
        st_next = st_reg;
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;
        // first compares after reset would see stale zeros
        if (st_reg.prime != PRIME_DONE) begin
            st_next.prime = st_reg.prime + 2'h1;
        end else begin
            edges = st_reg.sync2 ^ st_reg.prev;
        end
        st_next.change = edges;
        // a new edge wins over a clear in the same cycle
        st_next.delta = edges | (st_reg.delta &
            {4{~chg.clear}});
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign chg.level = st_reg.sync2;
    assign chg.change = st_reg.change;
    assign chg.delta = st_reg.delta;

    // ========================================================
    // checks
    sync_delay_a: assert property (@(posedge clock) disable iff (reset)
        st_reg.prime == PRIME_DONE |-> st_reg.sync2 == $past(pins, 2))
        else $error("pin level not two stages behind pin");
    delta_latch_a: assert property (@(posedge clock) disable iff (reset)
        |st_reg.change |-> ((st_reg.delta & st_reg.change)
        == st_reg.change)) else $error("edge not latched");
endmodule
`default_nettype wire

// ==== icis_top.sv ====
// module: input change register, interrupt status and mask, with an
// ahb-lite slave for software access.
// assumes the channel, break and counter event inputs come from logic
// on the same clock; the four gp inputs are asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
module icis_top (
    input wire logic clock,            // 200 MHz system clock
    input wire logic reset,            // sync reset, high
    input wire logic hsel,             // slave select
    input wire logic [31:0] haddr,     // byte address
    input wire logic [1:0] htrans,     // transfer type
    input wire logic hwrite,           // write when high
    input wire logic [2:0] hsize,      // word only
    input wire logic [31:0] hwdata,    // write data
    input wire logic hready,           // bus ready in
    output logic [31:0] hrdata,        // read data
    output logic hreadyout,            // slave ready
    output logic hresp,                // always okay
    input wire logic gp_input_0,       // async pin 0
    input wire logic gp_input_1,       // async pin 1
    input wire logic gp_input_2,       // async pin 2
    input wire logic gp_input_3,       // async pin 3
    input wire logic rx_irq_chan_a,    // chan a rx request level
    input wire logic tx_irq_chan_a,    // chan a tx request level
    input wire logic rx_irq_chan_b,    // chan b rx request level
    input wire logic tx_irq_chan_b,    // chan b tx request level
    input wire logic break_chg_a,      // chan a break edge pulse
    input wire logic break_chg_b,      // chan b break edge pulse
    input wire logic counter_tc,       // terminal count pulse
    output logic irq_out_n             // interrupt, low active
);
    import icis_pkg::*;

    typedef struct packed {
        logic [7:0] aux_control_reg;
        logic [7:0] irq_mask_reg;
        logic [7:0] irq_status_reg;
        logic [31:0] rdata;
        logic irq_n;
        logic ready;
        logic wr_pend;
        logic [5:0] wr_idx;
    } icis_top_st_t;

    icis_top_st_t st_reg;
    icis_top_st_t st_next;
    icis_chg_if chg ();

    // set wins over clear
    function automatic logic sticky(input logic old, input logic set,
            input logic clr);
        sticky = set | (old & ~clr);
    endfunction

    // ========================================================
    // pin change detector
    icis_chg_det u_det (
        .clock(clock),
        .reset(reset),
        .pins({gp_input_3, gp_input_2, gp_input_1, gp_input_0}),
        .chg(chg.det)
    );

    // ========================================================
    // bus decode
    logic accept;
    logic rd_now;
    logic [5:0] addr_idx;
    logic input_change_reg_read;
    logic wr_cmd;
    logic [7:0] input_change_reg;

    always_comb begin
        accept = hsel & htrans[1] & hready;
        rd_now = accept & ~hwrite;
        addr_idx = haddr[7:2];
        input_change_reg_read = rd_now & (addr_idx == IDX_INPUT_CHANGE);
        wr_cmd = st_reg.wr_pend & (st_reg.wr_idx == IDX_COMMAND);
        input_change_reg = {chg.delta, chg.level};
    end

    assign chg.clear = input_change_reg_read;

    // ========================================================
    // register and status update
    always_comb begin
        logic [7:0] s;
        logic chg_hit;
        s = st_reg.irq_status_reg;
        chg_hit = 1'b0;
        st_next = st_reg;
        st_next.ready = 1'b1;
        st_next.wr_pend = accept & hwrite;
        st_next.wr_idx = addr_idx;
        // read data captured in address phase, zero wait states
        if (rd_now) begin
            unique case (addr_idx)
                IDX_INPUT_CHANGE: st_next.rdata =
                    {24'h000000, input_change_reg};
                IDX_IRQ_STATUS: st_next.rdata =
                    {24'h000000, s};
                IDX_AUX_READBACK: st_next.rdata =
                    {24'h000000, st_reg.aux_control_reg};
                IDX_MASK_READBACK: st_next.rdata =
                    {24'h000000, st_reg.irq_mask_reg};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
        if (st_reg.wr_pend && st_reg.wr_idx == IDX_AUX_CONTROL) begin
            st_next.aux_control_reg = hwdata[7:0];
        end
        if (st_reg.wr_pend && st_reg.wr_idx == IDX_IRQ_MASK) begin
            st_next.irq_mask_reg = hwdata[7:0];
        end
        // only enabled pins reach the input change bit
        chg_hit = |(chg.change & st_reg.aux_control_reg[3:0]);
        s[ST_INPUT_CHG] = sticky(s[ST_INPUT_CHG], chg_hit,
            input_change_reg_read);
        s[ST_BREAK_B] = sticky(s[ST_BREAK_B], break_chg_b,
            wr_cmd & hwdata[CMD_CLR_BREAK_B]);
        s[ST_BREAK_A] = sticky(s[ST_BREAK_A], break_chg_a,
            wr_cmd & hwdata[CMD_CLR_BREAK_A]);
        s[ST_COUNTER] = sticky(s[ST_COUNTER], counter_tc,
            wr_cmd & hwdata[CMD_STOP_COUNTER]);
        // fill-level requests are levels owned by the channels
        s[ST_RX_B] = rx_irq_chan_b;
        s[ST_TX_B] = tx_irq_chan_b;
        s[ST_RX_A] = rx_irq_chan_a;
        s[ST_TX_A] = tx_irq_chan_a;
        st_next.irq_status_reg = s;
        st_next.irq_n = ~|(s & st_next.irq_mask_reg);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg.aux_control_reg <= AUX_RESET;
            st_reg.irq_mask_reg <= MASK_RESET;
            st_reg.irq_status_reg <= STATUS_RESET;
            st_reg.rdata <= 32'h00000000;
            st_reg.irq_n <= 1'b1;
            st_reg.ready <= 1'b1;
            st_reg.wr_pend <= 1'b0;
            st_reg.wr_idx <= 6'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata = st_reg.rdata;
    assign hreadyout = st_reg.ready;
    assign hresp = 1'b0;
    assign irq_out_n = st_reg.irq_n;

    // ========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic chg_en;
    assign chg_en = |(chg.change & st_reg.aux_control_reg[3:0]);

    pin_change_set_a: assert property (chg_en |=>
        st_reg.irq_status_reg[ST_INPUT_CHG])
        else $error("enabled change did not set status");
    disabled_pin_a: assert property (
        !st_reg.irq_status_reg[ST_INPUT_CHG] && !chg_en |=>
        !st_reg.irq_status_reg[ST_INPUT_CHG])
        else $error("status set by disabled pin");
    read_clears_a: assert property (input_change_reg_read && !chg_en &&
        chg.change == 4'h0 |=> !st_reg.irq_status_reg[ST_INPUT_CHG]
        && chg.delta == 4'h0)
        else $error("change read did not clear");
    irq_pin_a: assert property (
        |(st_reg.irq_status_reg & st_reg.irq_mask_reg) == !irq_out_n)
        else $error("interrupt pin disagrees with mask");
    status_read_a: assert property (rd_now &&
        addr_idx == IDX_IRQ_STATUS |=> hrdata ==
        {24'h000000, $past(st_reg.irq_status_reg)})
        else $error("status read wrong");
    change_read_a: assert property (rd_now &&
        addr_idx == IDX_INPUT_CHANGE |=> hrdata[3:0] ==
        $past(chg.level) && hrdata[7:4] == $past(chg.delta))
        else $error("change register read wrong");
    reset_clear_a: assert property ($past(reset) |->
        st_reg.irq_status_reg == STATUS_RESET)
        else $error("status not cleared by reset");
    break_hold_a: assert property (st_reg.irq_status_reg[ST_BREAK_B]
        && !(wr_cmd && hwdata[CMD_CLR_BREAK_B]) |=>
        st_reg.irq_status_reg[ST_BREAK_B])
        else $error("break b lost without command");
    break_set_a: assert property (break_chg_b |=>
        st_reg.irq_status_reg[ST_BREAK_B])
        else $error("break b edge not flagged");
    rx_follow_a: assert property (st_reg.irq_status_reg[ST_RX_B] ==
        $past(rx_irq_chan_b)) else $error("rx b bit stale");
    counter_a: assert property (counter_tc |=>
        st_reg.irq_status_reg[ST_COUNTER] [*2] or
        ##1 (wr_cmd && hwdata[CMD_STOP_COUNTER]))
        else $error("counter ready not held");

    pin_irq_c: cover property (chg_en ##1 !irq_out_n);
    clear_read_c: cover property (
        st_reg.irq_status_reg[ST_INPUT_CHG] ##1 input_change_reg_read);
    break_cmd_c: cover property (st_reg.irq_status_reg[ST_BREAK_B]
        && wr_cmd && hwdata[CMD_CLR_BREAK_B]);
endmodule
`default_nettype wire

// ==== icis_host_model.sv ====
// partner model: ahb-lite master standing in for the host processor.
// assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/100ps
`default_nettype none
module icis_host_model (
    input wire logic clock,         // system clock
    input wire logic hready,        // bus ready
    input wire logic [31:0] hrdata, // read data
    output logic hsel,              // slave select
    output logic [31:0] haddr,      // byte address
    output logic [1:0] htrans,      // transfer type
    output logic hwrite,            // write when high
    output logic [2:0] hsize,       // always word
    output logic [31:0] hwdata      // write data
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end
    // ========================================================
    // single word transfer, entered just after a rising edge
    task automatic bus_xfer(input logic wr, input logic [5:0] idx,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        // idle address is scrambled so a stale decode shows up
        haddr <= ~haddr;
        hwdata <= wr ? wd : ~hwdata;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~hwdata;
    endtask
endmodule
`default_nettype wire

// ==== tb_input_change_irq_status.sv ====
// testbench: register, pin change and interrupt tests of icis_top.
// assumes the host model as bus master and zero-latency event inputs.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb_input_change_irq_status;
    import icis_pkg::*;
    logic clock, reset, hsel, hwrite, hresp, hreadyout, irq_out_n;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, ev;
    logic [3:0] pins, lvl;
    int err_count = 0;
    int n_tests = 0;
    int pos[4] = '{ST_TX_A, ST_RX_A, ST_TX_B, ST_RX_B};
    icis_host_model host (.clock(clock), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    icis_top uut (.clock(clock), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gp_input_0(pins[0]),
        .gp_input_1(pins[1]), .gp_input_2(pins[2]), .gp_input_3(pins[3]),
        .rx_irq_chan_a(lvl[1]), .tx_irq_chan_a(lvl[0]),
        .rx_irq_chan_b(lvl[3]), .tx_irq_chan_b(lvl[2]),
        .break_chg_a(ev[0]), .break_chg_b(ev[1]), .counter_tc(ev[2]),
        .irq_out_n(irq_out_n));
    // ========================================================
    // helpers
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        host.bus_xfer(1'b1, idx, {24'h000000, d}, rd);
    endtask
    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        host.bus_xfer(1'b0, idx, 32'h00000000, rd);
        `CHK(rd, {24'h000000, exp})
    endtask
    // one edge lets the output settle after the last bus edge
    task automatic irq_chk(input logic exp);
        @(posedge clock);
        #1;
        `CHK(irq_out_n, exp)
    endtask
    // pins need sync plus edge compare, six edges is ample
    task automatic pin_set(input logic [3:0] v);
        pins <= v;
        repeat (6) @(posedge clock);
    endtask
    task automatic ev_pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge clock);
        ev[b] <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic tally_and_finish;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ========================================================
    // clock, watchdog and test sequence
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        tally_and_finish;
    end
    initial begin
        reset = 1'b1;
        pins = 4'h0;
        lvl = 4'h0;
        ev = 3'h0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        irq_chk(1'b1);
        `CHK(hresp, 1'b0)
        `CHK(hreadyout, 1'b1)
        rd_chk(IDX_IRQ_STATUS, STATUS_RESET);
        rd_chk(6'h3F, 8'h00);
        wr(IDX_AUX_CONTROL, 8'h05);
        wr(IDX_IRQ_MASK, 8'h80);
        pin_set(4'h2);
        rd_chk(IDX_IRQ_STATUS, 8'h00);
        irq_chk(1'b1);
        rd_chk(IDX_INPUT_CHANGE, 8'h22);
        rd_chk(IDX_INPUT_CHANGE, 8'h02);
        pin_set(4'h6);
        irq_chk(1'b0);
        rd_chk(IDX_IRQ_STATUS, 8'h80);
        rd_chk(IDX_INPUT_CHANGE, 8'h46);
        rd_chk(IDX_IRQ_STATUS, 8'h00);
        irq_chk(1'b1);
        `CHK(hresp, 1'b0)
        pin_set(4'h4);
        rd_chk(IDX_INPUT_CHANGE, 8'h24);
        pin_set(4'hD);
        rd_chk(IDX_IRQ_STATUS, 8'h80);
        rd_chk(IDX_INPUT_CHANGE, 8'h9D);
        rd_chk(IDX_AUX_READBACK, 8'h05);
        rd_chk(IDX_MASK_READBACK, 8'h80);
        wr(IDX_IRQ_MASK, 8'h00);
        ev_pulse(1);
        rd_chk(IDX_IRQ_STATUS, 8'h40);
        irq_chk(1'b1);
        rd_chk(IDX_INPUT_CHANGE, 8'h0D);
        rd_chk(IDX_IRQ_STATUS, 8'h40);
        wr(IDX_COMMAND, 8'(1 << CMD_CLR_BREAK_A));
        rd_chk(IDX_IRQ_STATUS, 8'h40);
        wr(IDX_COMMAND, 8'(1 << CMD_CLR_BREAK_B));
        rd_chk(IDX_IRQ_STATUS, 8'h00);
        ev_pulse(0);
        rd_chk(IDX_IRQ_STATUS, 8'h04);
        wr(IDX_COMMAND, 8'(1 << CMD_CLR_BREAK_A));
        rd_chk(IDX_IRQ_STATUS, 8'h00);
        ev_pulse(2);
        rd_chk(IDX_IRQ_STATUS, 8'h08);
        wr(IDX_IRQ_MASK, 8'h08);
        irq_chk(1'b0);
        wr(IDX_COMMAND, 8'(1 << CMD_STOP_COUNTER));
        rd_chk(IDX_IRQ_STATUS, 8'h00);
        irq_chk(1'b1);
        for (int i = 0; i < 4; i++) begin
            lvl <= 4'(1 << i);
            repeat (2) @(posedge clock);
            rd_chk(IDX_IRQ_STATUS, 8'(1 << pos[i]));
            wr(IDX_IRQ_MASK, 8'(1 << pos[i]));
            irq_chk(1'b0);
            wr(IDX_IRQ_MASK, ~8'(1 << pos[i]));
            irq_chk(1'b1);
            rd_chk(IDX_IRQ_STATUS, 8'(1 << pos[i]));
        end
        lvl <= 4'h0;
        // second reset in mid-run with a sticky bit set
        ev_pulse(2);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd_chk(IDX_IRQ_STATUS, STATUS_RESET);
        rd_chk(IDX_MASK_READBACK, MASK_RESET);
        irq_chk(1'b1);
        tally_and_finish;
    end
endmodule
`default_nettype wire
